// ==== verilog/psfs_sequencer.sv ====
// protection and sequencing logic of a current-limited high-side load switch
// Contract
// - below lockout threshold: switch off, inputs ignored
// - undervoltage held qualifying time turns switch off
// - after recovery interval switch turns back on
// - undervoltage off/on cycle repeats while low
// - enable turns switch on, polarity build option
// - fault flag open-drain, active low, after qualification
// - short variant: fault after short filter delay
// - short variant: flag held short delay after clear
// - surge variant: fault only if limiting at end
// - surge variant: flag held long delay after clear
// - surge variant: surges within period raise nothing
// - secondary limit during surge period, primary after
// - temperature trip: switch off, fault asserted
// - cooled to lower trip: switch back on
// - thermal cycling continues, never latches off
// - turn-on goes through soft-start ramp
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module psfs_sequencer #(
   parameter int TICK_CYCLES = psfs_pkg::TICK_CYCLES,
   parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
   parameter bit SURGE_VARIANT = 1'b0,
   parameter int RAMP_STEP_CYCLES = psfs_pkg::RAMP_STEP_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // comparators and enable pin
   input wire logic supply_ok_i,
   input wire logic enable_pin_i,
   input wire logic variable_input_undervoltage_i,
   input wire logic over_limit_i,
   input wire logic temp_trip_i,
   input wire logic temp_cooled_i,
   // switch drive
   output logic switch_on_o,
   output logic [psfs_pkg::GATE_W-1:0] gate_level_o,
   output logic secondary_limit_o,
   // fault line, open drain
   output logic fault_n_o,
   output logic fault_n_oe,
   // interrupt
   output logic irq_o,
   // axi4-lite write
   input wire logic [psfs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [psfs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import psfs_pkg::*;

   // ------------------------------------------------------------
   // build-time checks
   // ------------------------------------------------------------
   if (RAMP_STEP_CYCLES < 1) begin : g_bad_ramp
      $error("ramp step must be at least one cycle");
   end

   localparam int RCW = $clog2(RAMP_STEP_CYCLES + 1);
   localparam int QUAL_TICKS = SURGE_VARIANT ? SURGE_TICKS : FILTER_SHORT_TICKS;
   localparam int HOLD_TICKS = SURGE_VARIANT ? HOLD_LONG_TICKS : FILTER_SHORT_TICKS;

   // timer slot limits: qualify, hold, undervoltage, recovery
   function automatic int tmr_limit(input int idx);
      case (idx)
         0: tmr_limit = QUAL_TICKS;
         1: tmr_limit = HOLD_TICKS;
         2: tmr_limit = UV_QUAL_TICKS;
         default: tmr_limit = UV_RECOVER_TICKS;
      endcase
   endfunction

   // word decode, shared by the write and read paths
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      addr_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   psfs_state_t state_reg, state_next;
   logic tick;
   logic qual_exp, hold_exp, uv_exp, rec_exp;
   logic fault_reg, fault_next;
   logic inhibit_reg;
   logic [EV_W-1:0] status_reg, status_next, mask_reg, mask_next, events;
   logic supply_prev_reg;
   logic [RCW-1:0] ramp_cnt_reg;
   logic ramp_step, ramp_done;
   logic en_active, run_ok, conducting, conducting_next, cond_active;
   logic aw_hold_reg, w_hold_reg, aw_take, w_take, aw_have, w_have, wr_fire, rd_fire;
   logic [ADDR_W-1:0] awaddr_reg, wr_addr;
   logic [31:0] wdata_reg, wr_data;
   logic wstrb0_reg, wr_lane0;
   logic wr_ctrl, wr_status, wr_mask, wr_mapped, rd_mapped;
   logic [31:0] rd_word;
   logic [GATE_W-1:0] gate_next;

   // ------------------------------------------------------------
   // timebase and interval timers
   // ------------------------------------------------------------
   psfs_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_o(tick)
   );

   psfs_tmr_if tmr[4] ();

   // all intervals count the same tick
   for (genvar i = 0; i < 4; i++) begin : g_tmr
      assign tmr[i].tick = tick;
      psfs_qual_timer #(.LIMIT(tmr_limit(i))) u_tmr (
         .aclk(aclk),
         .aresetn(aresetn),
         .tmr(tmr[i].timer)
      );
   end

   // timer run conditions; a false run restarts the count
   assign cond_active = (conducting && over_limit_i) || (state_reg == PSFS_THERM);
   assign tmr[0].run = supply_ok_i && conducting && over_limit_i;
   assign tmr[1].run = supply_ok_i && fault_reg && !cond_active;
   assign tmr[2].run = supply_ok_i && conducting && variable_input_undervoltage_i;
   assign tmr[3].run = supply_ok_i && (state_reg == PSFS_UV_WAIT);
   assign qual_exp = tmr[0].expired;
   assign hold_exp = tmr[1].expired;
   assign uv_exp = tmr[2].expired;
   assign rec_exp = tmr[3].expired;

   // ------------------------------------------------------------
   // switch sequencing
   // ------------------------------------------------------------
   assign en_active = (enable_pin_i == ENABLE_ACTIVE_HIGH);
   assign run_ok = supply_ok_i && en_active && !inhibit_reg;
   assign conducting = (state_reg == PSFS_RAMP) || (state_reg == PSFS_ON);
   assign conducting_next = (state_next == PSFS_RAMP) || (state_next == PSFS_ON);
   assign ramp_step = (ramp_cnt_reg == RCW'(RAMP_STEP_CYCLES - 1));
   assign ramp_done = (gate_level_o == GATE_MAX);

   // thermal trip outranks undervoltage, both outrank ramp completion
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PSFS_OFF: begin
            if (run_ok) state_next = PSFS_RAMP;
         end
         PSFS_RAMP, PSFS_ON: begin
            if (!run_ok) state_next = PSFS_OFF;
            else if (temp_trip_i) state_next = PSFS_THERM;
            else if (uv_exp) state_next = PSFS_UV_WAIT;
            else if (state_reg == PSFS_RAMP && ramp_done) state_next = PSFS_ON;
         end
         PSFS_UV_WAIT: begin
            if (rec_exp) state_next = run_ok ? PSFS_RAMP : PSFS_OFF;
         end
         PSFS_THERM: begin
            if (temp_cooled_i) state_next = run_ok ? PSFS_RAMP : PSFS_OFF;
         end
         default: state_next = PSFS_OFF;
      endcase
      if (!supply_ok_i) state_next = PSFS_OFF;
   end

   // gate drive: stepped ramp on every turn-on, zero when off
   assign gate_next = !conducting_next ? '0 :
                      (state_next == PSFS_ON) ? GATE_MAX :
                      (ramp_step && !ramp_done) ? gate_level_o + 1'b1 : gate_level_o;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= PSFS_OFF;
         switch_on_o <= 1'b0;
         gate_level_o <= '0;
         ramp_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         switch_on_o <= conducting_next;
         gate_level_o <= gate_next;
         ramp_cnt_reg <= (ramp_step || state_next != PSFS_RAMP) ? '0 : ramp_cnt_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // fault flag and current limit selection
   // ------------------------------------------------------------
   // set wins over the hold release; lockout clears the flag
   assign fault_next = !supply_ok_i ? 1'b0 :
                       (qual_exp || state_next == PSFS_THERM) ? 1'b1 :
                       hold_exp ? 1'b0 : fault_reg;

   // line only ever pulled low; the pull-up lives outside
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_reg <= 1'b0;
         fault_n_o <= 1'b0;
         fault_n_oe <= 1'b0;
         secondary_limit_o <= 1'b0;
      end else begin
         fault_reg <= fault_next;
         fault_n_o <= 1'b0;
         fault_n_oe <= fault_next;
         secondary_limit_o <= SURGE_VARIANT && conducting_next && !qual_exp;
      end
   end

   // ------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------
   assign events[EV_FAULT_BIT] = fault_next && !fault_reg;
   assign events[EV_UV_BIT] = (state_next == PSFS_UV_WAIT) && (state_reg != PSFS_UV_WAIT);
   assign events[EV_THERM_BIT] = (state_next == PSFS_THERM) && (state_reg != PSFS_THERM);
   assign events[EV_LOCKOUT_BIT] = supply_prev_reg && !supply_ok_i;
   // write-one-to-clear; a same-cycle event keeps its bit
   assign status_next = (status_reg & ~(wr_status ? wr_data[EV_W-1:0] : '0)) | events;
   assign mask_next = wr_mask ? wr_data[EV_W-1:0] : mask_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= '0;
         mask_reg <= '0;
         inhibit_reg <= 1'b0;
         supply_prev_reg <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         inhibit_reg <= wr_ctrl ? wr_data[CTRL_INHIBIT_BIT] : inhibit_reg;
         supply_prev_reg <= supply_ok_i;
         irq_o <= |(status_next & mask_next);
      end
   end

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   // address and data may arrive in either order; one write in flight
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign aw_have = aw_hold_reg || aw_take;
   assign w_have = w_hold_reg || w_take;
   assign wr_fire = aw_have && w_have && !s_axi_bvalid;
   assign wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
   assign wr_lane0 = w_hold_reg ? wstrb0_reg : s_axi_wstrb[0];
   assign wr_mapped = addr_hit(wr_addr, OFS_CTRL) || addr_hit(wr_addr, OFS_STATE) ||
                      addr_hit(wr_addr, OFS_IRQ_STATUS) || addr_hit(wr_addr, OFS_IRQ_MASK);
   assign wr_ctrl = wr_fire && wr_lane0 && addr_hit(wr_addr, OFS_CTRL);
   assign wr_status = wr_fire && wr_lane0 && addr_hit(wr_addr, OFS_IRQ_STATUS);
   assign wr_mask = wr_fire && wr_lane0 && addr_hit(wr_addr, OFS_IRQ_MASK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb0_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         aw_hold_reg <= aw_have && !wr_fire;
         w_hold_reg <= w_have && !wr_fire;
         if (aw_take) awaddr_reg <= s_axi_awaddr;
         if (w_take) wdata_reg <= s_axi_wdata;
         if (w_take) wstrb0_reg <= s_axi_wstrb[0];
         s_axi_awready <= !(aw_have && !wr_fire) && !(wr_fire || (s_axi_bvalid && !s_axi_bready));
         s_axi_wready <= !(w_have && !wr_fire) && !(wr_fire || (s_axi_bvalid && !s_axi_bready));
         s_axi_bvalid <= wr_fire || (s_axi_bvalid && !s_axi_bready);
         if (wr_fire) s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // read mux; the state word shows live sequencing status
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign rd_mapped = addr_hit(s_axi_araddr, OFS_CTRL) || addr_hit(s_axi_araddr, OFS_STATE) ||
                      addr_hit(s_axi_araddr, OFS_IRQ_STATUS) || addr_hit(s_axi_araddr, OFS_IRQ_MASK);
   assign rd_word = addr_hit(s_axi_araddr, OFS_CTRL) ? {31'h00000000, inhibit_reg} :
                    addr_hit(s_axi_araddr, OFS_STATE) ?
                       {27'h0000000, secondary_limit_o, state_reg == PSFS_THERM,
                        state_reg == PSFS_UV_WAIT, fault_reg, switch_on_o} :
                    addr_hit(s_axi_araddr, OFS_IRQ_STATUS) ? {28'h0000000, status_reg} :
                    addr_hit(s_axi_araddr, OFS_IRQ_MASK) ? {28'h0000000, mask_reg} : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !(rd_fire || (s_axi_rvalid && !s_axi_rready));
         s_axi_rvalid <= rd_fire || (s_axi_rvalid && !s_axi_rready);
         if (rd_fire) s_axi_rdata <= rd_word;
         if (rd_fire) s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_conducting_ok;
      conducting && run_ok && !temp_trip_i;
   endsequence

   sequence s_cool_restart;
      (state_reg == PSFS_THERM) && temp_cooled_i && run_ok;
   endsequence

   chk_lockout_off: assert property (!supply_ok_i |=> !switch_on_o && !fault_n_oe)
      else $error("switch or fault active under lockout");
   chk_enable_level: assert property (!en_active |=> !switch_on_o)
      else $error("switch on without asserted enable");
   chk_uv_turnoff: assert property (s_conducting_ok ##0 uv_exp |=> !switch_on_o ##1 !switch_on_o)
      else $error("undervoltage did not turn switch off");
   chk_uv_recover: assert property ((state_reg == PSFS_UV_WAIT) && rec_exp && run_ok |=> switch_on_o)
      else $error("no automatic restart after recovery");
   chk_thermal_trip: assert property (supply_ok_i && temp_trip_i && conducting |=> !switch_on_o && fault_n_oe)
      else $error("thermal trip not handled");
   chk_thermal_resume: assert property (s_cool_restart |=> switch_on_o)
      else $error("no restart after cooling");
   chk_fault_qualified: assert property ($rose(fault_n_oe) |-> $past(qual_exp) || $past(state_next == PSFS_THERM))
      else $error("fault flag raised without qualification");
   chk_fault_hold: assert property ($fell(fault_n_oe) && $past(supply_ok_i) |-> $past(hold_exp))
      else $error("fault flag released before hold delay");
   chk_qual_restart: assert property (!tmr[0].run |=> !qual_exp)
      else $error("qualification did not restart");
   chk_surge_limit: assert property (qual_exp |=> !secondary_limit_o)
      else $error("secondary limit kept after surge period");
   chk_soft_start: assert property ($rose(switch_on_o) |-> gate_level_o != GATE_MAX)
      else $error("switch turned on without ramp");
endmodule // psfs_sequencer
`default_nettype wire

// ==== common/psfs_pkg.sv ====
// constants, register map and types shared by the power switch fault sequencer
package psfs_pkg;
   // ------------------------------------------------------------
   // clock and internal timebase
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_PER_US * TICK_US;
   // ------------------------------------------------------------
   // delay intervals in ms, and in ticks (least times round up)
   // ------------------------------------------------------------
   localparam int FILTER_SHORT_MS = 32;
   localparam int SURGE_MS = 128;
   localparam int HOLD_LONG_MS = 128;
   localparam int UV_QUAL_MS = 32;
   localparam int UV_RECOVER_MS = 128;
   localparam int FILTER_SHORT_TICKS = (FILTER_SHORT_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int SURGE_TICKS = (SURGE_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int HOLD_LONG_TICKS = (HOLD_LONG_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int UV_QUAL_TICKS = (UV_QUAL_MS * 1000 + TICK_US - 1) / TICK_US;
   localparam int UV_RECOVER_TICKS = (UV_RECOVER_MS * 1000 + TICK_US - 1) / TICK_US;
   // ------------------------------------------------------------
   // soft-start ramp
   // ------------------------------------------------------------
   localparam int GATE_W = 8;
   localparam logic [GATE_W-1:0] GATE_MAX = 8'hFF;
   localparam int RISE_US = 1000;
   localparam int RAMP_STEP_CYCLES = RISE_US * CLK_PER_US / 255;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hC;
   localparam int CTRL_INHIBIT_BIT = 0;
   localparam int ST_ON_BIT = 0;
   localparam int ST_FAULT_BIT = 1;
   localparam int ST_UV_BIT = 2;
   localparam int ST_THERM_BIT = 3;
   localparam int ST_SURGE_BIT = 4;
   localparam int EV_W = 4;
   localparam int EV_FAULT_BIT = 0;
   localparam int EV_UV_BIT = 1;
   localparam int EV_THERM_BIT = 2;
   localparam int EV_LOCKOUT_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // switch sequencing states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PSFS_OFF,
      PSFS_RAMP,
      PSFS_ON,
      PSFS_UV_WAIT,
      PSFS_THERM
   } psfs_state_t;
endpackage

// ==== common/psfs_tmr_if.sv ====
// control handshake between the sequencer and one interval timer
`timescale 1ns/1ns
`default_nettype none
interface psfs_tmr_if;
   logic tick;
   logic run;
   logic expired;
   modport ctl (output tick, output run, input expired);
   modport timer (input tick, input run, output expired);
endinterface // psfs_tmr_if
`default_nettype wire

// ==== verilog/psfs_tick_gen.sv ====
// prescaler producing the one-cycle internal timebase tick
`timescale 1ns/1ns
`default_nettype none
module psfs_tick_gen #(
   parameter int TICK_CYCLES = psfs_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // timebase
   output logic tick_o
);
   import psfs_pkg::*;
   localparam int CW = $clog2(TICK_CYCLES + 1);
   logic [CW-1:0] cnt_reg;

   if (TICK_CYCLES < 1) begin : g_bad
      $error("tick period must be at least one cycle");
   end

   // free-running divider, so every interval shares one phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt_reg == CW'(TICK_CYCLES - 1));
         cnt_reg <= (cnt_reg == CW'(TICK_CYCLES - 1)) ? '0 : cnt_reg + 1'b1;
      end
   end
endmodule // psfs_tick_gen
`default_nettype wire

// ==== verilog/psfs_qual_timer.sv ====
// interval timer: counts ticks while run is high, restarts when run drops
`timescale 1ns/1ns
`default_nettype none
module psfs_qual_timer #(
   parameter int LIMIT = 32
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   psfs_tmr_if.timer tmr
);
   localparam int CW = $clog2(LIMIT + 1);
   logic [CW-1:0] cnt_reg;
   logic expired_reg;

   if (LIMIT < 1) begin : g_bad
      $error("timer limit must be at least one tick");
   end

   // expired stays high until run falls; a dropped run loses all progress
   always_ff @(posedge aclk) begin
      if (!aresetn || !tmr.run) begin
         cnt_reg <= '0;
         expired_reg <= 1'b0;
      end else if (tmr.tick && !expired_reg) begin
         cnt_reg <= cnt_reg + 1'b1;
         expired_reg <= (cnt_reg == CW'(LIMIT - 1));
      end
   end

   assign tmr.expired = expired_reg;
endmodule // psfs_qual_timer
`default_nettype wire

// ==== sim/psfs_host_model.sv ====
// host side model: enable driver and pulled-up shared fault line
`timescale 1ns/1ns
`default_nettype none
module psfs_host_model #(
   parameter bit ACTIVE_HIGH = 1'h1
) (
   // host request
   input wire logic want_on,
   // fault drive from the device
   input wire logic fault_n_o,
   input wire logic fault_n_oe,
   // pin levels
   output logic enable_pin,
   output logic fault_line
);
   // pin level follows the polarity option of the device
   assign enable_pin = want_on ~^ ACTIVE_HIGH;
   // resistor holds the line high unless a source sinks it
   assign fault_line = fault_n_oe ? fault_n_o : 1'h1;
endmodule // psfs_host_model
`default_nettype wire

// ==== sim/psfs_sequencer_bench.sv ====
// self-checking bench: host model, both fault variants, register bus
`timescale 1ns/1ns
`default_nettype none
module psfs_sequencer_bench;
   import psfs_pkg::*;
   localparam int TICK = 4; // short tick keeps the run brief
   // stimulus, named as the ports it feeds
   logic aclk = 1'h0, aresetn = 1'h0, supply_ok_i = 1'h0, want_on = 1'h1, over_limit_i = 1'h0, snap = 1'h0;
   logic variable_input_undervoltage_i = 1'h0, temp_trip_i = 1'h0, temp_cooled_i = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seen;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   // observed
   logic enable_pin_i, switch_on_o, secondary_limit_o, fault_n_o, fault_n_oe, irq_o, fault_line, s_oe, s_sec;
   logic enable_pin_n; // low-true pin level for the surge instance
   logic [GATE_W-1:0] gate_level_o;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] expq[$], mskq[$];
   int errors = 0, comparisons = 0, n;
   always #25 aclk = ~aclk;
   psfs_host_model #(.ACTIVE_HIGH(1'h1)) i_psfs_host_model (.want_on, .fault_n_o, .fault_n_oe,
      .enable_pin(enable_pin_i), .fault_line);
   // low-true enable option rides on the surge instance
   psfs_host_model #(.ACTIVE_HIGH(1'h0)) i_psfs_host_model_low (.want_on, .fault_n_o(1'h0), .fault_n_oe(s_oe),
      .enable_pin(enable_pin_n), .fault_line());
   psfs_sequencer #(.TICK_CYCLES(TICK), .SURGE_VARIANT(1'h0), .RAMP_STEP_CYCLES(1)) i_psfs_sequencer (.*);
   // surge variant with low-true enable; only its fault and limit pins are watched
   psfs_sequencer #(.TICK_CYCLES(TICK), .ENABLE_ACTIVE_HIGH(1'h0), .SURGE_VARIANT(1'h1), .RAMP_STEP_CYCLES(1))
      i_psfs_sequencer_surge (.*, .enable_pin_i(enable_pin_n),
      .switch_on_o(), .gate_level_o(), .secondary_limit_o(s_sec), .fault_n_o(), .fault_n_oe(s_oe), .irq_o(),
      .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(),
      .s_axi_rresp(), .s_axi_rvalid());
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wait_c(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic note(input logic [31:0] e, input logic [31:0] m);
      expq.push_back(e);
      mskq.push_back(m);
   endtask
   // pin sample bits: switch, line, irq, gate full, surge flag, secondary
   task automatic look(input logic [5:0] e, input logic [5:0] m);
      @(posedge aclk);
      note({26'h0, e}, {26'h0, m});
      snap <= 1'h1;
      @(posedge aclk);
      snap <= 1'h0;
   endtask
   // write: both channels offered together, each dropped once taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      note({30'h0, r}, 32'h3);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge aclk);
      note(e, 32'hFFFFFFFF);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // monitor: oldest note is matched against each result as it appears
   always @(posedge aclk) begin
      seen = snap ? {26'h0, s_sec, s_oe, gate_level_o == GATE_MAX, irq_o, fault_line, switch_on_o}
         : s_axi_rvalid ? s_axi_rdata : {30'h0, s_axi_bresp};
      if (snap || (s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
         chk(seen & mskq.pop_front(), expq.pop_front());
      end
      // every word address is mapped, so each read answers okay
      if (s_axi_rvalid && s_axi_rready) begin
         chk({30'h0, s_axi_rresp}, {30'h0, RESP_OKAY});
      end
   end
   // watchdog, far beyond the few thousand cycles the run needs
   initial begin
      wait_c(30000);
      errors++;
      close_out();
   end
   initial begin
      void'($urandom(32'h8DEB));
      wait_c(16);
      aresetn <= 1'h1;
      wait_c(4);
      look(6'h02, 6'h0F);
      rd(OFS_STATE, 32'h0);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      rd(4'h2, 32'h0);
      // low bits drop out of the word decode; a write without lane 0 is ignored
      s_axi_wstrb <= 4'hE;
      wr(4'h2, 32'h1, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      wr(OFS_IRQ_MASK, 32'h5, RESP_OKAY);
      rd(OFS_IRQ_MASK, 32'h5);
      rd(OFS_CTRL, 32'h0);
      supply_ok_i <= 1'h1;
      wait_c(2);
      look(6'h01, 6'h09);
      wait_c(300);
      look(6'h09, 6'h09);
      // random transient, then a restarted count must not fire early
      over_limit_i <= 1'h1;
      wait_c(40 + $urandom % 60);
      over_limit_i <= 1'h0;
      wait_c(2);
      over_limit_i <= 1'h1;
      wait_c((FILTER_SHORT_TICKS - 1) * TICK - 8);
      look(6'h22, 6'h32);
      wait_c(TICK + 10);
      look(6'h24, 6'h36);
      rd(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
      look(6'h00, 6'h06);
      wait_c((SURGE_TICKS - 1) * TICK - 160);
      look(6'h20, 6'h30);
      wait_c(TICK + 24);
      look(6'h10, 6'h30);
      over_limit_i <= 1'h0;
      wait_c((FILTER_SHORT_TICKS - 1) * TICK - 8);
      look(6'h10, 6'h12);
      wait_c(TICK + 10);
      look(6'h32, 6'h32);
      wait_c((HOLD_LONG_TICKS - 1) * TICK - 150);
      look(6'h10, 6'h10);
      wait_c(TICK + 24);
      look(6'h00, 6'h10);
      // sagging input: masked event, off, recovery, and again
      variable_input_undervoltage_i <= 1'h1;
      wait_c((UV_QUAL_TICKS - 1) * TICK - 8);
      look(6'h01, 6'h05);
      wait_c(TICK + 10);
      look(6'h00, 6'h05);
      rd(OFS_STATE, 32'h4);
      rd(OFS_IRQ_STATUS, 32'h2);
      wait_c((UV_RECOVER_TICKS - 1) * TICK - 50);
      look(6'h00, 6'h01);
      wait_c(TICK + 50);
      look(6'h01, 6'h01);
      wait_c(UV_QUAL_TICKS * TICK + 10);
      look(6'h00, 6'h01);
      variable_input_undervoltage_i <= 1'h0;
      wait_c(UV_RECOVER_TICKS * TICK + 300);
      look(6'h09, 6'h09);
      for (n = 0; n < 2; n++) begin
         temp_trip_i <= 1'h1;
         wait_c(2);
         look(6'h04, 6'h07);
         temp_trip_i <= 1'h0;
         temp_cooled_i <= 1'h1;
         wait_c(2);
         look(6'h01, 6'h01);
         temp_cooled_i <= 1'h0;
         wr(OFS_IRQ_STATUS, 32'hF, RESP_OKAY);
      end
      want_on <= 1'h0;
      wait_c(2);
      look(6'h00, 6'h21);
      supply_ok_i <= 1'h0;
      wait_c(2);
      look(6'h02, 6'h03);
      close_out();
   end
endmodule // psfs_sequencer_bench
`default_nettype wire
